// *** core/p2ds_pkg.sv ***
// Purpose: Shared constants and types for the phase 2 device data sequencer
// Assumes: 50 MHz core clock, APB register access with 32-bit data
// Notes:   Codes are kept in their 8-bit form where both widths exist
package p2ds_pkg;
    // Register byte offsets
    localparam logic [7:0] P2DS_OFS_CTRL   = 8'h00;
    localparam logic [7:0] P2DS_OFS_CFG    = 8'h04;
    localparam logic [7:0] P2DS_OFS_SERIAL = 8'h08;
    localparam logic [7:0] P2DS_OFS_STATUS = 8'h0C;
    localparam logic [7:0] P2DS_OFS_LAST   = 8'h10;
    // CTRL fields
    localparam int P2DS_CTRL_START    = 0;
    localparam int P2DS_CTRL_MODE_LSB = 1;
    localparam int P2DS_CTRL_TEN_BIT  = 3;
    localparam int P2DS_CTRL_SV_EN    = 4;
    localparam int P2DS_CTRL_AZ_EN    = 5;
    localparam int P2DS_CTRL_SYNC_EN  = 6;
    // CFG fields
    localparam int P2DS_CFG_USER_LSB  = 0;
    localparam int P2DS_CFG_RANGE_LSB = 8;
    localparam int P2DS_CFG_BDERS_LSB = 12;
    // Reset values
    localparam logic [31:0] P2DS_CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] P2DS_CFG_RST    = 32'h0000_0000;
    localparam logic [31:0] P2DS_SERIAL_RST = 32'h0000_0000;
    // Mode 2 codes, 8-bit form
    localparam logic [7:0] P2DS_C8_ZERO    = 8'h7A;
    localparam logic [7:0] P2DS_C8_ONE     = 8'h79;
    localparam logic [7:0] P2DS_C8_DEL100  = 8'h80;
    localparam logic [7:0] P2DS_C8_DEL250  = 8'h86;
    localparam logic [7:0] P2DS_C8_DELOTH  = 8'h83;
    localparam logic [7:0] P2DS_C8_DEV_ERR = 8'h7D;
    localparam logic [7:0] P2DS_C8_DEV_OK  = 8'h7B;
    localparam logic [7:0] P2DS_C8_ACC_MAX = 8'h74;
    localparam logic [7:0] P2DS_C8_ACC_MIN = 8'h8C;
    // Mode 3 code bases
    localparam logic [9:0] P2DS_C10_NN_BASE  = 10'h200;
    localparam logic [9:0] P2DS_C10_NYB_BASE = 10'h210;
    // State vectors
    localparam logic [2:0] P2DS_SV_SENSOR = 3'b000;
    localparam logic [2:0] P2DS_SV_DEVICE = 3'b001;
    localparam logic [2:0] P2DS_SV_STATUS = 3'b110;
    // Sequence counts
    localparam int P2DS_LEAD_CNT   = 64;
    localparam int P2DS_SERIAL_CNT = 32;
    localparam int P2DS_USER_CNT   = 12;
    localparam int P2DS_TRAIL_CNT  = 8;
    localparam int P2DS_GROUPS     = 8;
    localparam int P2DS_NYB_REPS   = 32;
    // Fixed mode 3 nybbles; maker nybble value is arbitrary
    localparam logic [3:0] P2DS_NYB_PROTO = 4'h3;
    localparam logic [3:0] P2DS_NYB_COUNT = 4'h0;
    localparam logic [3:0] P2DS_NYB_MAKER = 4'h5;
    localparam logic [3:0] P2DS_NYB_TYPE  = 4'h1;
    // Range select encoding
    localparam logic [2:0] P2DS_RG_50  = 3'd0;
    localparam logic [2:0] P2DS_RG_100 = 3'd1;
    localparam logic [2:0] P2DS_RG_200 = 3'd3;
    localparam logic [2:0] P2DS_RG_250 = 3'd4;
    // Timing
    localparam int P2DS_CLK_PERIOD_NS   = 20;
    localparam int P2DS_MSG_INTERVAL_NS = 456000;
    localparam int P2DS_MSG_INTERVAL_CYC = P2DS_MSG_INTERVAL_NS / P2DS_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        P2DS_K_DELIM = 2'b00,
        P2DS_K_BIT   = 2'b01,
        P2DS_K_NN    = 2'b10,
        P2DS_K_NYB   = 2'b11
    } p2ds_kind_e;

    typedef struct packed {
        logic [9:0] code;
        logic [2:0] sv;
    } p2ds_msg_s;
endpackage

// *** core/p2ds_timer.sv ***
// Purpose: Message pacing, internal interval or control module sync pulse
// Assumes: sync_pulse_i already synchronised to clk_i
// Notes:   Counter restarts whenever the sequence is idle
`timescale 1ns/1ps
module p2ds_timer
    import p2ds_pkg::*;
#(
    parameter int unsigned INTERVAL_CYC = P2DS_MSG_INTERVAL_CYC
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic nrst_i,
    // Control
    input  wire logic run_i,
    input  wire logic sync_en_i,
    input  wire logic sync_pulse_i,
    // Tick
    output logic      tick_o
);
    logic [15:0] cnt_q;
    logic        sync_q;
    wire         sync_rise = sync_pulse_i & ~sync_q;
    wire         cnt_end   = (cnt_q == 16'(INTERVAL_CYC - 1));

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cnt_q  <= 16'h0000;
            sync_q <= 1'b0;
            tick_o <= 1'b0;
        end else begin
            sync_q <= sync_pulse_i;
            cnt_q  <= (!run_i || cnt_end) ? 16'h0000 : cnt_q + 16'h0001;
            tick_o <= run_i & (sync_en_i ? sync_rise : cnt_end);
        end
    end
endmodule

// *** core/p2ds_coder.sv ***
// Purpose: Maps a message kind and payload to its transmitted code
// Assumes: Combinational, used by the sequencer only
// Notes:   8-bit codes are left justified in 10-bit mode
`timescale 1ns/1ps
module p2ds_coder
    import p2ds_pkg::*;
(
    // Selection
    input  wire p2ds_kind_e kind_i,
    input  wire logic       bit_i,
    input  wire logic [3:0] nyb_i,
    input  wire logic [2:0] range_i,
    input  wire logic       ten_bit_i,
    // Code
    output logic [9:0]      code_o
);
    wire [7:0] delim8 = (range_i == P2DS_RG_100) ? P2DS_C8_DEL100 :
                        (range_i == P2DS_RG_250) ? P2DS_C8_DEL250 : P2DS_C8_DELOTH;
    wire [7:0] bit8   = bit_i ? P2DS_C8_ONE : P2DS_C8_ZERO;
    wire [7:0] sel8   = (kind_i == P2DS_K_DELIM) ? delim8 : bit8;
    wire [9:0] m2code = ten_bit_i ? {sel8, 2'b00} : {2'b00, sel8};
    wire [9:0] nncode = P2DS_C10_NN_BASE | {6'h00, nyb_i};
    wire [9:0] nbcode = P2DS_C10_NYB_BASE | {6'h00, nyb_i};

    assign code_o = (kind_i == P2DS_K_NN)  ? nncode :
                    (kind_i == P2DS_K_NYB) ? nbcode : m2code;
endmodule

// *** core/p2ds_top.sv ***
// Purpose: Phase 2 device data message sequencer with APB registers
// Assumes: Pin side sync pulse is asynchronous; APB master keeps the protocol
// Notes:   One message per tick on MSG_CODE_O with a one-cycle MSG_VALID_O
//          Writes land on the edge that sees PREADY_O high; config locked while busy
// Contract
// - Mode 2 sends user, config, serial bits
// - 8-bit: zero 0x7A, one 0x79
// - 10-bit Mode 2 codes shifted left two
// - Delimiter chosen from range setting
// - Sixty-four leading delimiters first
// - Then 32 serial-number bit messages
// - Then 12 user bit messages
// - Then eight delimiters close a group
// - Group repeated seven more times
// - User bits: sync, range, user byte
// - Tag device 001, status 110, sensor 000
// - Full-range coding when SV on, AZ off (code also needs mode 2 or 3)
// - Error 0x7D, OK 0x7B, accel limits (accel limit codes are defined but never sent)
// - Mode 3 uses codes 0x200 to 0x21F
// - One nybble per Mode 3 message
// - Nybble number code precedes each nybble
// - Each nybble number repeated 16 times
// - User register nybbles 7 and 8
// - Mode 3 with 8-bit is config error
// - Ascending nybbles, NN and value codes
`timescale 1ns/1ps
module p2ds_top
    import p2ds_pkg::*;
#(
    parameter int unsigned INTERVAL_CYC = P2DS_MSG_INTERVAL_CYC
) (
    // Clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        NRST_I,
    // APB slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic             PREADY_O,
    output logic [31:0]      PRDATA_O,
    output logic             PSLVERR_O,
    // Control module sync pulse pin
    input  wire logic        SYNC_PULSE_I,
    // Message stream
    output logic             MSG_VALID_O,
    output logic [9:0]       MSG_CODE_O,
    output logic [2:0]       MSG_SV_O,
    output logic             FULL_RANGE_O,
    output logic             BUSY_O,
    output logic             CFG_ERROR_O
);
    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_LEAD   = 3'b001,
        S_SERIAL = 3'b010,
        S_USER   = 3'b011,
        S_TRAIL  = 3'b100,
        S_M3     = 3'b101,
        S_DONE   = 3'b110,
        S_ERROR  = 3'b111
    } p2ds_state_e;

    p2ds_state_e state_q, state_d;
    logic [31:0] ctrl_q, cfg_q, serial_q;
    logic [6:0]  cnt_q, cnt_d;
    logic [2:0]  grp_q, grp_d;
    logic [3:0]  nyb_q, nyb_d;
    logic [4:0]  rep_q, rep_d;
    logic        done_q, done_d;
    logic        sync_m_q, sync_s_q;
    logic        tick;
    logic [9:0]  code;
    p2ds_msg_s   last_q;

    // Configuration fields
    wire [1:0] mode     = ctrl_q[P2DS_CTRL_MODE_LSB +: 2];
    wire       ten_bit  = ctrl_q[P2DS_CTRL_TEN_BIT];
    wire       sv_en    = ctrl_q[P2DS_CTRL_SV_EN];
    wire       az_en    = ctrl_q[P2DS_CTRL_AZ_EN];
    wire       sync_en  = ctrl_q[P2DS_CTRL_SYNC_EN];
    wire [7:0] user_register = cfg_q[P2DS_CFG_USER_LSB +: 8];
    wire [2:0] range_sel     = cfg_q[P2DS_CFG_RANGE_LSB +: 3];
    wire [1:0] bde_rs        = cfg_q[P2DS_CFG_BDERS_LSB +: 2];
    wire [11:0] user_bits    = {sync_en, range_sel, user_register};

    // Sequence occupies the link
    function automatic logic running(input p2ds_state_e st);
        running = (st != S_IDLE) && (st != S_DONE);
    endfunction

    // APB decode
    wire apb_setup  = PSEL_I & ~PENABLE_I;
    wire apb_access = PSEL_I & PENABLE_I & ~PREADY_O;
    wire hit_ctrl   = (PADDR_I == P2DS_OFS_CTRL);
    wire hit_cfg    = (PADDR_I == P2DS_OFS_CFG);
    wire hit_serial = (PADDR_I == P2DS_OFS_SERIAL);
    wire hit_status = (PADDR_I == P2DS_OFS_STATUS);
    wire hit_last   = (PADDR_I == P2DS_OFS_LAST);
    wire hit_any    = hit_ctrl | hit_cfg | hit_serial | hit_status | hit_last;
    // Write commits with the completing edge of the access
    wire wr_ok      = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & hit_any;
    wire busy       = running(state_q);
    // Config locked while sequence runs
    wire wr_cfg     = wr_ok & ~busy;

    // Register write strobes and stored images
    wire        wr_ctrl   = wr_cfg & hit_ctrl;
    wire        wr_cfgreg = wr_cfg & hit_cfg;
    wire        wr_serial = wr_cfg & hit_serial;
    wire [31:0] ctrl_wr   = {25'h000_0000, PWDATA_I[6:0]};
    wire [31:0] cfg_wr    = {18'h0_0000, PWDATA_I[13:0]};

    wire start_req  = wr_ok & hit_ctrl & PWDATA_I[P2DS_CTRL_START] & ~busy;
    wire start_mode = start_req & PWDATA_I[P2DS_CTRL_MODE_LSB + 1];
    wire start_err  = start_mode & PWDATA_I[P2DS_CTRL_MODE_LSB] & ~PWDATA_I[P2DS_CTRL_TEN_BIT];

    wire [31:0] status_word = {19'h0_0000, nyb_q, grp_q, done_q, state_q == S_ERROR, busy, state_q};
    wire [31:0] rd_word = hit_ctrl   ? {ctrl_q[31:1], 1'b0} :
                          hit_cfg    ? cfg_q :
                          hit_serial ? serial_q :
                          hit_status ? status_word :
                          hit_last   ? {19'h0_0000, last_q} : 32'h0000_0000;

    // Mode 3 nybble value for nybble number nyb_q (0 is nybble 1)
    function automatic logic [3:0] m3_value(input logic [3:0] idx, input logic [2:0] rg,
                                            input logic [1:0] br, input logic [7:0] ur,
                                            input logic [31:0] sn);
        logic [3:0] rcode;
        rcode = (rg == P2DS_RG_100) ? 4'h0 : (rg == P2DS_RG_50) ? 4'h1 :
                (rg == P2DS_RG_200) ? 4'h2 : 4'h3;
        unique case (idx)
            4'd0:    m3_value = P2DS_NYB_PROTO;
            4'd1:    m3_value = P2DS_NYB_COUNT;
            4'd2:    m3_value = P2DS_NYB_MAKER;
            4'd3:    m3_value = P2DS_NYB_TYPE;
            4'd4:    m3_value = rcode;
            4'd5:    m3_value = {2'b00, br};
            4'd6:    m3_value = ur[7:4];
            4'd7:    m3_value = ur[3:0];
            default: m3_value = sn[5'(4'd15 - idx) * 4 +: 4];
        endcase
    endfunction

    // Message kind and payload for the current position
    wire        m3_is_nn  = ~rep_q[0];
    wire [3:0]  m3_nyb    = m3_is_nn ? nyb_q
                                     : m3_value(nyb_q, range_sel, bde_rs, user_register, serial_q);
    wire        m2_bit    = (state_q == S_SERIAL) ? serial_q[5'(31 - cnt_q)]
                                                  : user_bits[4'(11 - cnt_q)];
    wire p2ds_kind_e kind = (state_q == S_M3) ? (m3_is_nn ? P2DS_K_NN : P2DS_K_NYB) :
                            ((state_q == S_SERIAL) || (state_q == S_USER)) ? P2DS_K_BIT
                                                                          : P2DS_K_DELIM;
    wire        emit_dev  = (state_q != S_IDLE) & (state_q != S_DONE) & (state_q != S_ERROR);
    wire [7:0]  status8   = (state_q == S_ERROR) ? P2DS_C8_DEV_ERR : P2DS_C8_DEV_OK;
    wire [9:0]  status10  = ten_bit ? {status8, 2'b00} : {2'b00, status8};
    wire [9:0]  tx_code   = emit_dev ? code : status10;
    wire [2:0]  tx_sv     = ~sv_en ? P2DS_SV_SENSOR :
                            emit_dev ? P2DS_SV_DEVICE : P2DS_SV_STATUS;
    wire        tx_fire   = tick & (state_q != S_IDLE);
    // Sensor coding spans full range in device data modes when SV is on and AZ is off
    wire        full_rng  = sv_en & ~az_en & (mode[1] | busy);

    p2ds_timer #(
        .INTERVAL_CYC (INTERVAL_CYC)
    ) u_timer (
        .clk_i        (CLOCK_I),
        .nrst_i       (NRST_I),
        .run_i        (state_q != S_IDLE),
        .sync_en_i    (sync_en),
        .sync_pulse_i (sync_s_q),
        .tick_o       (tick)
    );

    p2ds_coder u_coder (
        .kind_i    (kind),
        .bit_i     (m2_bit),
        .nyb_i     (m3_nyb),
        .range_i   (range_sel),
        .ten_bit_i (ten_bit),
        .code_o    (code)
    );

    // Field ends of the Mode 2 and Mode 3 walks
    wire lead_end   = (cnt_q == 7'(P2DS_LEAD_CNT - 1));
    wire serial_end = (cnt_q == 7'(P2DS_SERIAL_CNT - 1));
    wire user_end   = (cnt_q == 7'(P2DS_USER_CNT - 1));
    wire trail_end  = (cnt_q == 7'(P2DS_TRAIL_CNT - 1));
    wire last_grp   = (grp_q == 3'(P2DS_GROUPS - 1));
    wire rep_end    = (rep_q == 5'(P2DS_NYB_REPS - 1));
    wire last_nyb   = (nyb_q == 4'd15);

    // Sequence advance
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        grp_d   = grp_q;
        nyb_d   = nyb_q;
        rep_d   = rep_q;
        done_d  = done_q;
        if (start_req) begin
            cnt_d  = 7'd0;
            grp_d  = 3'd0;
            nyb_d  = 4'd0;
            rep_d  = 5'd0;
            done_d = 1'b0;
            state_d = start_err ? S_ERROR :
                      !start_mode ? state_q :
                      PWDATA_I[P2DS_CTRL_MODE_LSB] ? S_M3 : S_LEAD;
        end else if (tick) begin
            unique case (state_q)
                S_LEAD: begin
                    cnt_d = cnt_q + 7'd1;
                    if (lead_end) begin
                        cnt_d   = 7'd0;
                        state_d = S_SERIAL;
                    end
                end
                S_SERIAL: begin
                    cnt_d = cnt_q + 7'd1;
                    if (serial_end) begin
                        cnt_d   = 7'd0;
                        state_d = S_USER;
                    end
                end
                S_USER: begin
                    cnt_d = cnt_q + 7'd1;
                    if (user_end) begin
                        cnt_d   = 7'd0;
                        state_d = S_TRAIL;
                    end
                end
                S_TRAIL: begin
                    cnt_d = cnt_q + 7'd1;
                    if (trail_end) begin
                        cnt_d   = 7'd0;
                        grp_d   = grp_q + 3'd1;
                        state_d = last_grp ? S_DONE : S_SERIAL;
                        done_d  = last_grp;
                    end
                end
                S_M3: begin
                    rep_d = rep_q + 5'd1;
                    if (rep_end) begin
                        nyb_d = nyb_q + 4'd1;
                        if (last_nyb) begin
                            state_d = S_DONE;
                            done_d  = 1'b1;
                        end
                    end
                end
                S_IDLE, S_DONE, S_ERROR: begin
                    state_d = state_q;
                end
            endcase
        end
    end

    // Pin synchroniser
    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            sync_m_q <= 1'b0;
            sync_s_q <= 1'b0;
        end else begin
            sync_m_q <= SYNC_PULSE_I;
            sync_s_q <= sync_m_q;
        end
    end

    // APB answer, one wait state
    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            PREADY_O  <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O  <= apb_access;
            PSLVERR_O <= apb_access & ~hit_any;
            PRDATA_O  <= (apb_access & ~PWRITE_I) ? rd_word : 32'h0000_0000;
        end
    end

    // Configuration registers
    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            ctrl_q   <= P2DS_CTRL_RST;
            cfg_q    <= P2DS_CFG_RST;
            serial_q <= P2DS_SERIAL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= ctrl_wr;
            end
            if (wr_cfgreg) begin
                cfg_q <= cfg_wr;
            end
            if (wr_serial) begin
                serial_q <= PWDATA_I;
            end
        end
    end

    // Sequencer state
    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            state_q <= S_IDLE;
            cnt_q   <= 7'd0;
            grp_q   <= 3'd0;
            nyb_q   <= 4'd0;
            rep_q   <= 5'd0;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            grp_q   <= grp_d;
            nyb_q   <= nyb_d;
            rep_q   <= rep_d;
            done_q  <= done_d;
        end
    end

    // Message outputs
    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            last_q       <= '0;
            MSG_VALID_O  <= 1'b0;
            MSG_CODE_O   <= 10'h000;
            MSG_SV_O     <= P2DS_SV_SENSOR;
            FULL_RANGE_O <= 1'b0;
            BUSY_O       <= 1'b0;
            CFG_ERROR_O  <= 1'b0;
        end else begin
            MSG_VALID_O  <= tx_fire;
            if (tx_fire) begin
                MSG_CODE_O <= tx_code;
                MSG_SV_O   <= tx_sv;
                last_q     <= '{code: tx_code, sv: tx_sv};
            end
            FULL_RANGE_O <= full_rng;
            BUSY_O       <= running(state_d);
            CFG_ERROR_O  <= (state_d == S_ERROR);
        end
    end
endmodule

// *** verif/p2ds_ctrl_model.sv ***
// Purpose: Control module side, sync pulse source
// Assumes: Pin idles low between frames
// Notes:   Pulses only while run_i is high
`timescale 1ns/1ps
module p2ds_ctrl_model #(
    parameter int PERIOD = 30
) (
    // Clock and frame enable
    input  wire logic clk_i,
    input  wire logic run_i,
    // Pin
    output logic      sync_pulse_o
);
    int cnt_q;
    int cnt_d;
    assign cnt_d = (!run_i || cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
    assign sync_pulse_o = run_i && cnt_q < 5;
    always_ff @(posedge clk_i) begin
        cnt_q <= cnt_d;
    end
endmodule

// *** verif/p2ds_chk.sv ***
// Purpose: Message stream checker
// Assumes: Messages at least nine cycles apart
// Notes:   Bound to the top module
`timescale 1ns/1ps
module p2ds_chk
    import p2ds_pkg::*;
#(
    parameter int unsigned INTERVAL_CYC = P2DS_MSG_INTERVAL_CYC
) (
    // Clock and reset
    input wire logic       CLOCK_I,
    input wire logic       NRST_I,
    // Stream
    input wire logic       MSG_VALID_O,
    input wire logic [9:0] MSG_CODE_O,
    input wire logic [2:0] MSG_SV_O,
    input wire logic       FULL_RANGE_O,
    input wire logic       BUSY_O,
    input wire logic       CFG_ERROR_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!NRST_I);
    a_device_codes: assert property (MSG_VALID_O && MSG_SV_O == 3'b001 |->
        MSG_CODE_O inside {10'h079, 10'h07A, 10'h080, 10'h083, 10'h086, 10'h1E4, 10'h1E8, [10'h200:10'h21F]})
        else $error("device data code outside the allowed set");
    a_error_code: assert property (MSG_VALID_O && CFG_ERROR_O |->
        MSG_CODE_O inside {10'h07D, 10'h1F4} && MSG_SV_O != 3'b001)
        else $error("error state sends wrong code");
    a_error_holds: assert property (CFG_ERROR_O |=> CFG_ERROR_O)
        else $error("configuration error dropped");
    a_error_busy: assert property (CFG_ERROR_O |-> BUSY_O)
        else $error("error state not busy");
    a_sv_kinds: assert property (MSG_VALID_O |-> MSG_SV_O inside {3'b000, 3'b001, 3'b110})
        else $error("undefined state vector");
    a_full_range_sv: assert property (MSG_VALID_O && FULL_RANGE_O |-> MSG_SV_O != 3'b000)
        else $error("full range coding without state vector");
    a_msg_spacing: assert property (MSG_VALID_O |=> !MSG_VALID_O [*8])
        else $error("messages too close");
    a_code_holds: assert property (!MSG_VALID_O |-> $stable(MSG_CODE_O) && $stable(MSG_SV_O))
        else $error("code changed without a message");
    c_error: cover property (MSG_VALID_O && CFG_ERROR_O);
    c_nybble: cover property (MSG_VALID_O && MSG_CODE_O inside {[10'h210:10'h21F]});
    c_ten_one: cover property (MSG_VALID_O && MSG_CODE_O == 10'h1E4);
endmodule
bind p2ds_top p2ds_chk #(.INTERVAL_CYC(INTERVAL_CYC)) p2ds_chk_i (.CLOCK_I(CLOCK_I), .NRST_I(NRST_I),
    .MSG_VALID_O(MSG_VALID_O), .MSG_CODE_O(MSG_CODE_O), .MSG_SV_O(MSG_SV_O),
    .FULL_RANGE_O(FULL_RANGE_O), .BUSY_O(BUSY_O), .CFG_ERROR_O(CFG_ERROR_O));

// *** verif/p2ds_top_tb.sv ***
// Purpose: Self-checking bench for the sequencer
// Assumes: Short message interval of 20 cycles
// Notes:   Expected messages queued, monitor compares
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module p2ds_top_tb;
    import p2ds_pkg::*;
    logic        clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, sync_run = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, serial;
    logic        prdy, perr, sync_pulse, mv, fr, busy, cerr;
    logic [9:0]  code;
    logic [2:0]  sv, rng;
    logic [7:0]  user;
    logic [1:0]  bders;
    logic [12:0] exp_q[$];
    int          num_errors = 0, n_compared = 0;

    p2ds_top #(.INTERVAL_CYC(20)) p2ds_top_i (.CLOCK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(prdy), .PRDATA_O(prdata),
        .PSLVERR_O(perr), .SYNC_PULSE_I(sync_pulse), .MSG_VALID_O(mv), .MSG_CODE_O(code), .MSG_SV_O(sv),
        .FULL_RANGE_O(fr), .BUSY_O(busy), .CFG_ERROR_O(cerr));
    p2ds_ctrl_model p2ds_ctrl_model_i (.clk_i(clk), .run_i(sync_run), .sync_pulse_o(sync_pulse));

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic final_report;
        if (num_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    function automatic logic [9:0] c2(input logic [7:0] c, input logic t);
        return t ? {c, 2'b00} : {2'b00, c};
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int k;
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (prdy !== 1'b1 && k < 50);
        rd = prdata;
        er = perr;
        psel <= 0; pen <= 0;
        if (k >= 50) begin
            num_errors++;
            final_report();
        end
    endtask

    // One full run: md mode, t ten-bit, s state vector, y sync mode
    task automatic go(input logic [1:0] md, input logic t, input logic s, input logic y);
        logic [31:0] v;
        logic        e;
        logic [2:0]  svd;
        logic [7:0]  dl;
        logic [11:0] ub;
        logic        az;
        logic [3:0]  nyb[16];
        int          k;
        serial = $urandom;
        user = 8'($urandom);
        rng = 3'($urandom_range(7));
        bders = 2'($urandom_range(3));
        svd = s ? P2DS_SV_DEVICE : P2DS_SV_SENSOR;
        az = md[0] & t;
        apb(1, P2DS_OFS_CFG, {18'h0, bders, 1'b0, rng, user}, v, e);
        apb(1, P2DS_OFS_SERIAL, serial, v, e);
        apb(0, P2DS_OFS_CFG, 32'h0, v, e);
        `CHK("cfg", {18'h0, bders, 1'b0, rng, user}, v)
        `CHK("cfg_err", 1'b0, e)
        dl = rng == P2DS_RG_100 ? P2DS_C8_DEL100 : rng == P2DS_RG_250 ? P2DS_C8_DEL250 : P2DS_C8_DELOTH;
        ub = {y, rng, user};
        if (md == 2'd2) begin
            repeat (64) push(c2(dl, t), svd);
            repeat (8) begin
                for (k = 31; k >= 0; k--) push(c2(serial[k] ? 8'h79 : 8'h7A, t), svd);
                for (k = 11; k >= 0; k--) push(c2(ub[k] ? 8'h79 : 8'h7A, t), svd);
                repeat (8) push(c2(dl, t), svd);
            end
        end else if (t) begin
            nyb[0] = 4'h3;
            nyb[1] = 4'h0;
            nyb[2] = P2DS_NYB_MAKER;
            nyb[3] = 4'h1;
            nyb[4] = rng == P2DS_RG_100 ? 4'h0 : rng == P2DS_RG_50 ? 4'h1 : rng == P2DS_RG_200 ? 4'h2 : 4'h3;
            nyb[5] = {2'b00, bders};
            nyb[6] = user[7:4];
            nyb[7] = user[3:0];
            for (k = 0; k < 8; k++) nyb[k + 8] = 4'(serial >> (28 - 4 * k));
            for (k = 0; k < 16; k++) begin
                repeat (16) begin
                    push(10'h200 + 10'(k), svd);
                    push(10'h210 + 10'(nyb[k]), svd);
                end
            end
        end
        if (md == 2'd3 && !t)
            repeat (3) push(10'h07D, s ? P2DS_SV_STATUS : P2DS_SV_SENSOR);
        else
            push(c2(8'h7B, t), s ? P2DS_SV_STATUS : P2DS_SV_SENSOR);
        sync_run <= y;
        apb(1, P2DS_OFS_CTRL, {25'h0, y, az, s, t, md, 1'b1}, v, e);
        for (k = 0; k < 40000 && exp_q.size() > 0; k++) begin
            @(posedge clk);
            if (k == 40) begin
                `CHK("full_range", s & ~az, fr)
                `CHK("busy", 1'b1, busy)
                `CHK("cfg_error", md == 2'd3 && !t, cerr)
            end
        end
        if (exp_q.size() > 0) begin
            num_errors++;
            final_report();
        end
        sync_run <= 0;
        nrst <= 0;
        repeat (5) @(posedge clk);
        nrst <= 1;
    endtask

    task automatic push(input logic [9:0] c, input logic [2:0] s);
        exp_q.push_back({c, s});
    endtask

    always @(posedge clk) begin
        logic [12:0] ex;
        if (nrst === 1'b1 && mv === 1'b1) begin
            ex = exp_q.size() > 0 ? exp_q.pop_front() : 13'h1FFF;
            `CHK("message", ex, {code, sv})
        end
    end

    initial begin
        logic [31:0] v;
        logic        e;
        v = $urandom(65472);
        repeat (5) @(posedge clk);
        nrst <= 1;
        apb(0, P2DS_OFS_CTRL, 32'h0, v, e);
        `CHK("ctrl_reset", P2DS_CTRL_RST, v)
        apb(0, 8'h14, 32'h0, v, e);
        `CHK("unmapped_err", 1'b1, e)
        go(2'd2, 0, 1, 0);
        go(2'd2, 1, 0, 1);
        go(2'd3, 1, 1, 0);
        go(2'd3, 0, 1, 0);
        final_report();
    end
endmodule
